// ### src/modem_datapath.sv
// Modem data path: buffers, priority, repeat, serial filter, test transmissions
// Function
// R1: Forwarded packets are at most 1 kB.
// R2: Basic repeater sends all received data to serial.
// R3: Advanced modes send only locally routed data to serial.
// R4: Serial data goes on air in ordinary format.
// R5: Other-class messages are dropped.
// R6: Sync opens each transmission; heard sync enters receive.
// R7: Serial data is buffered during sync.
// R8: Transmitter stops after pause and empty buffer.
// R9: Transmit buffer holds at most 1 kB.
// R10: Terminal holds data while CTS is low.
// R11: Overflow clears buffer, restarts transmission.
// R12: Radio data is buffered for serial.
// R13: Serial data during receive is buffered.
// R14: Transmit priority sends at once.
// R15: Receive priority holds serial data.
// R16: Serial data waits until forwarding ends.
// R17: Short test: numbered LF lines, 200 ms apart.
// R18: Continuous tests resume after power returns.
// R19: Long test: 40 s on, 10 s off.
// R20: Register writes start and stop tests.
// R21: Strength query needs commands enabled.
// R22: Default is basic, receive priority.
// R23: Pause is idle character times.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps

module byte_fifo (
   input  wire logic                   clk_i,   // Clock
   input  wire logic                   rst_i,   // Sync reset
   input  wire logic                   clr_i,   // Empty the buffer
   input  wire logic                   wr_i,    // Push
   input  wire logic [7:0]             wd_i,    // Push data
   input  wire logic                   rd_i,    // Pop
   output logic      [7:0]             rd_o,    // Head byte
   output logic      [modem_pkg::CW-1:0] cnt_o, // Fill level
   output logic                        empty_o, // No data
   output logic                        full_o   // No room
);
   logic [7:0]               mem_r [modem_pkg::BUF_DEPTH];
   logic [modem_pkg::AW-1:0] wp_r;
   logic [modem_pkg::AW-1:0] rp_r;
   logic [modem_pkg::CW-1:0] cnt_r;
   wire                      do_wr = wr_i && !full_o;
   wire                      do_rd = rd_i && !empty_o;
   assign rd_o    = mem_r[rp_r];
   assign cnt_o   = cnt_r;
   assign empty_o = (cnt_r == '0);
   assign full_o  = (cnt_r == modem_pkg::CW'(modem_pkg::BUF_DEPTH));

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem_r[wp_r] <= wd_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_r + modem_pkg::AW'(do_wr);
         rp_r  <= rp_r + modem_pkg::AW'(do_rd);
         cnt_r <= cnt_r + modem_pkg::CW'(do_wr) - modem_pkg::CW'(do_rd);
      end
   end
endmodule // byte_fifo

module modem_datapath #(
   parameter int SYNC_CYCLES      = modem_pkg::SYNC_US * modem_pkg::CLK_KHZ / 1000,
   parameter int SHORT_GAP_CYCLES = modem_pkg::SHORT_GAP_MS * modem_pkg::CLK_KHZ,
   parameter int LONG_ON_CYCLES   = modem_pkg::LONG_ON_MS * modem_pkg::CLK_KHZ,
   parameter int LONG_OFF_CYCLES  = modem_pkg::LONG_OFF_MS * modem_pkg::CLK_KHZ
) (
   input  wire logic        REF_CLK_I,       // 25 MHz clock
   input  wire logic        SYS_RST_I,       // Sync reset, high
   input  wire logic [3:0]  REG_ADDR_I,      // Register index
   input  wire logic [15:0] REG_WDATA_I,     // Write data
   input  wire logic        REG_WR_I,        // Write strobe
   input  wire logic        REG_RD_I,        // Read strobe
   output logic      [15:0] REG_RDATA_O,     // Read data, next cycle
   input  wire logic        SER_VALID_I,     // Serial byte in
   input  wire logic [7:0]  SER_DATA_I,      // Serial byte
   input  wire logic        CHAR_TICK_I,     // One character time
   output logic             CTS_O,           // Terminal may send
   output logic             SER_OUT_VALID_O, // Byte to serial port
   output logic      [7:0]  SER_OUT_DATA_O,  // Serial out byte
   input  wire logic        SER_OUT_READY_I, // Serial port accepts
   input  wire logic        RF_SYNC_DET_I,   // Sync heard on air
   input  wire logic        RF_RX_VALID_I,   // Received byte
   input  wire logic [7:0]  RF_RX_DATA_I,    // Received data
   input  wire logic        RF_RX_END_I,     // End of message
   input  wire logic        RF_RX_ADV_I,     // Sender in advanced mode
   input  wire logic        RF_RX_LOCAL_I,   // Routed to local port
   input  wire logic        RF_RX_FWD_I,     // Routed for forwarding
   output logic             TX_ON_O,         // Transmitter keyed
   output logic             TX_SYNC_O,       // Sync being sent
   output logic             TX_VALID_O,      // Byte to modulator
   output logic      [7:0]  TX_DATA_O,       // Modulator byte
   input  wire logic        TX_READY_I,      // Modulator accepts
   input  wire logic        RSSI_QUERY_I,    // Strength query decoded
   input  wire logic [7:0]  RSSI_I,          // Last strength
   output logic             RSSI_VALID_O,    // Query answer pulse
   output logic      [7:0]  RSSI_O,          // Query answer
   input  wire logic [2:0]  NV_TEST_I,       // Stored test mode
   output logic      [2:0]  NV_TEST_O        // Test mode to store
);
   modem_pkg::state_t st_r, st_nxt;
   modem_pkg::src_t   src_r, src_nxt;
   logic [15:0] cfg_r;
   logic [2:0]  test_r;
   logic        boot_r;
   logic [31:0] tmr_r;
   logic [31:0] lrun_r;
   logic [7:0]  idle_r;
   logic [7:0]  seq_r;
   logic [3:0]  tidx_r;
   logic        txv_r;
   logic [7:0]  txd_r;
   logic        sov_r;
   logic [7:0]  sod_r;
   logic        cts_r;
   logic        ton_r;
   logic        tsync_r;
   logic [15:0] rdata_r;
   logic        rsv_r;
   logic [7:0]  rsd_r;
   logic [2:0]  nv_r;

   wire [2:0] mode     = cfg_r[modem_pkg::CFG_MODE_LSB +: modem_pkg::MODE_W];
   wire       cmd_en   = cfg_r[modem_pkg::CFG_CMD_BIT];
   wire [7:0] pause_ln = cfg_r[modem_pkg::CFG_PAUSE_LSB +: modem_pkg::PAUSE_W];
   wire       adv_mode = (mode == modem_pkg::MODE_ADV_MST) || (mode == modem_pkg::MODE_ADV_SLV);
   wire       tst_on   = (test_r != modem_pkg::TEST_OFF);
   wire       tst_shrt = (test_r == modem_pkg::TEST_SHORT) || (test_r == modem_pkg::TEST_CSHORT);
   wire       tst_cont = (test_r == modem_pkg::TEST_CSHORT) || (test_r == modem_pkg::TEST_CLONG);

   // Transmit buffer
   wire [7:0]               tx_head;
   wire [modem_pkg::CW-1:0] tx_cnt;
   wire                     tx_empty;
   wire                     tx_full;
   wire                     ovf    = SER_VALID_I && tx_full;        // [R11]
   wire                     tx_wr  = SER_VALID_I && !tx_full;       // [R7] [R13]
   wire                     paused = (idle_r >= pause_ln);          // [R23]

   // Receive filter
   wire class_ok = (RF_RX_ADV_I == adv_mode); // [R5]
   wire to_ser   = class_ok && (adv_mode ? RF_RX_LOCAL_I : 1'b1); // [R2] [R3]
   wire to_fwd   = class_ok && ((mode == modem_pkg::MODE_REPEAT) || (adv_mode && RF_RX_FWD_I));
   wire in_recv  = (st_r == modem_pkg::ST_RECV);
   wire rx_wr    = in_recv && RF_RX_VALID_I && to_ser; // [R12]
   wire fwd_wr   = in_recv && RF_RX_VALID_I && to_fwd; // [R1]
   wire [7:0] rx_head;
   wire       rx_empty;
   wire       so_ld = !sov_r || SER_OUT_READY_I;
   wire       rx_rd = so_ld && !rx_empty;
   wire [7:0] fwd_head;
   wire       fwd_empty;
   // Source for radio bytes
   wire       in_send   = (st_r == modem_pkg::ST_SEND);
   wire       tst_empty = (tidx_r == modem_pkg::TEST_LEN);
   wire       src_empty = (src_r == modem_pkg::SRC_SER) ? tx_empty :
                          (src_r == modem_pkg::SRC_FWD) ? fwd_empty : tst_empty;
   wire [7:0] src_byte  = (src_r == modem_pkg::SRC_SER) ? tx_head :
                          (src_r == modem_pkg::SRC_FWD) ? fwd_head :
                          modem_pkg::test_byte(tidx_r, seq_r);
   wire       tx_ld     = in_send && (!txv_r || TX_READY_I);
   wire       take      = tx_ld && !src_empty;
   wire       tx_rd     = take && (src_r == modem_pkg::SRC_SER); // [R4]
   wire       fwd_rd    = take && (src_r == modem_pkg::SRC_FWD);
   wire       drained   = src_empty && !txv_r;
   wire       tx_clr    = ovf;

   // Timers
   wire       sync_done = (tmr_r >= 32'(SYNC_CYCLES - 1));
   wire       gap_done  = (tmr_r >= (tst_shrt ? 32'(SHORT_GAP_CYCLES - 1) : 32'(LONG_OFF_CYCLES - 1)));
   wire       long_done = (lrun_r >= 32'(LONG_ON_CYCLES - 1));

   byte_fifo u_txbuf (.clk_i(REF_CLK_I), .rst_i(SYS_RST_I), .clr_i(tx_clr), .wr_i(tx_wr), .wd_i(SER_DATA_I),
      .rd_i(tx_rd), .rd_o(tx_head), .cnt_o(tx_cnt), .empty_o(tx_empty), .full_o(tx_full)); // [R9]
   byte_fifo u_rxbuf (.clk_i(REF_CLK_I), .rst_i(SYS_RST_I), .clr_i(1'b0), .wr_i(rx_wr), .wd_i(RF_RX_DATA_I),
      .rd_i(rx_rd), .rd_o(rx_head), .cnt_o(), .empty_o(rx_empty), .full_o());
   byte_fifo u_fwdbuf (.clk_i(REF_CLK_I), .rst_i(SYS_RST_I), .clr_i(1'b0), .wr_i(fwd_wr), .wd_i(RF_RX_DATA_I),
      .rd_i(fwd_rd), .rd_o(fwd_head), .cnt_o(), .empty_o(fwd_empty), .full_o());

   always_comb begin
      st_nxt  = st_r;
      src_nxt = src_r;
      case (st_r)
         modem_pkg::ST_IDLE: begin
            if (tst_on) begin
               st_nxt  = modem_pkg::ST_SYNC;
               src_nxt = modem_pkg::SRC_TEST;
            end else if (RF_SYNC_DET_I) begin
               st_nxt = modem_pkg::ST_RECV; // [R6]
            end else if (!tx_empty) begin
               st_nxt  = modem_pkg::ST_SYNC; // [R15]
               src_nxt = modem_pkg::SRC_SER;
            end
         end
         modem_pkg::ST_RECV: begin
            if (mode == modem_pkg::MODE_TX_PRIO && !tx_empty) begin
               st_nxt  = modem_pkg::ST_SYNC; // [R14]
               src_nxt = modem_pkg::SRC_SER;
            end else if (RF_RX_END_I) begin
               if (!fwd_empty || fwd_wr) begin
                  st_nxt  = modem_pkg::ST_SYNC; // [R16]
                  src_nxt = modem_pkg::SRC_FWD;
               end else begin
                  st_nxt = modem_pkg::ST_IDLE;
               end
            end
         end
         modem_pkg::ST_SYNC: begin
            if (src_r == modem_pkg::SRC_TEST && !tst_on) begin
               st_nxt = modem_pkg::ST_IDLE;
            end else if (sync_done && !(ovf && src_r == modem_pkg::SRC_SER)) begin
               st_nxt = modem_pkg::ST_SEND; // [R6]
            end
         end
         modem_pkg::ST_SEND: begin
            case (src_r)
               modem_pkg::SRC_SER: begin
                  if (ovf) begin
                     st_nxt = modem_pkg::ST_SYNC; // [R11]
                  end else if (drained && paused) begin
                     st_nxt = modem_pkg::ST_IDLE; // [R8]
                  end
               end
               modem_pkg::SRC_FWD: begin
                  if (drained) begin
                     st_nxt = modem_pkg::ST_IDLE; // [R16]
                  end
               end
               default: begin
                  if (!tst_on) begin
                     st_nxt = modem_pkg::ST_IDLE; // [R20]
                  end else if (drained && (tst_shrt || long_done)) begin
                     st_nxt = modem_pkg::ST_GAP; // [R17] [R19]
                  end
               end
            endcase
         end
         modem_pkg::ST_GAP: begin
            if (!tst_on) begin
               st_nxt = modem_pkg::ST_IDLE;
            end else if (gap_done) begin
               st_nxt = modem_pkg::ST_SYNC; // [R17] [R19]
            end
         end
         default: st_nxt = modem_pkg::ST_IDLE;
      endcase
   end

   // Restart forces a fresh sync period after overflow
   wire restart = ovf && (src_r == modem_pkg::SRC_SER) &&
                  (st_r == modem_pkg::ST_SYNC || st_r == modem_pkg::ST_SEND);
   wire on_nxt  = (st_nxt == modem_pkg::ST_SYNC) || (st_nxt == modem_pkg::ST_SEND);

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         st_r    <= modem_pkg::ST_IDLE;
         src_r   <= modem_pkg::SRC_SER;
         tmr_r   <= '0;
         ton_r   <= 1'b0;
         tsync_r <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         src_r   <= src_nxt;
         tmr_r   <= (st_nxt != st_r || restart) ? '0 : tmr_r + 1'b1;
         ton_r   <= on_nxt; // [R8] [R19]
         tsync_r <= (st_nxt == modem_pkg::ST_SYNC);
      end
   end

   // Long test run time and message sequencing
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         lrun_r <= '0;
         seq_r  <= '0;
         tidx_r <= '0;
      end else begin
         if (st_r == modem_pkg::ST_GAP || !tst_on) begin
            lrun_r <= '0;
         end else if (on_nxt) begin
            lrun_r <= long_done ? lrun_r : lrun_r + 1'b1; // [R19]
         end
         if (!tst_on) begin
            tidx_r <= '0;
         end else if (take && src_r == modem_pkg::SRC_TEST) begin
            tidx_r <= tidx_r + 1'b1;
         end else if (in_send && src_r == modem_pkg::SRC_TEST && drained) begin
            tidx_r <= '0; // [R17]
            seq_r  <= seq_r + 1'b1;
         end
      end
   end

   // Radio byte and serial byte output stages
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         txv_r <= 1'b0;
         txd_r <= 8'h00;
         sov_r <= 1'b0;
         sod_r <= 8'h00;
      end else begin
         if (take) begin
            txv_r <= 1'b1;
            txd_r <= src_byte;
         end else if (TX_READY_I) begin
            txv_r <= 1'b0;
         end
         if (rx_rd) begin
            sov_r <= 1'b1; // [R12]
            sod_r <= rx_head;
         end else if (SER_OUT_READY_I) begin
            sov_r <= 1'b0;
         end
      end
   end

   // Pause detector and flow control
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         idle_r <= '0;
         cts_r  <= 1'b0;
      end else begin
         if (SER_VALID_I) begin
            idle_r <= '0;
         end else if (CHAR_TICK_I && !paused) begin
            idle_r <= idle_r + 1'b1; // [R23]
         end
         cts_r <= (tx_cnt < modem_pkg::CTS_LEVEL); // [R10]
      end
   end

   // Register port; stored test mode is taken once after reset
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         cfg_r   <= modem_pkg::CFG_RST; // [R22]
         test_r  <= modem_pkg::TEST_OFF;
         boot_r  <= 1'b1;
         rdata_r <= 16'h0000;
      end else begin
         boot_r <= 1'b0;
         if (REG_WR_I && REG_ADDR_I == modem_pkg::REG_CFG) begin
            cfg_r <= REG_WDATA_I;
         end
         if (REG_WR_I && REG_ADDR_I == modem_pkg::REG_TEST) begin
            test_r <= (REG_WDATA_I[2:0] > modem_pkg::TEST_CLONG) ?
                      modem_pkg::TEST_OFF : REG_WDATA_I[2:0];     // [R20]
         end else if (boot_r && (NV_TEST_I == modem_pkg::TEST_CSHORT ||
                                 NV_TEST_I == modem_pkg::TEST_CLONG)) begin
            test_r <= NV_TEST_I; // [R18]
         end
         if (REG_RD_I) begin
            case (REG_ADDR_I)
               modem_pkg::REG_CFG:  rdata_r <= cfg_r;
               modem_pkg::REG_TEST: rdata_r <= {13'h0000, test_r};
               modem_pkg::REG_STAT: rdata_r <= {seq_r, ton_r, paused, cts_r, src_r, st_r};
               modem_pkg::REG_LVL:  rdata_r <= {5'h00, tx_cnt};
               default:             rdata_r <= 16'h0000;
            endcase
         end else begin
            rdata_r <= 16'h0000;
         end
      end
   end

   // Strength query answer and stored test mode
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         rsv_r <= 1'b0;
         rsd_r <= 8'h00;
         nv_r  <= modem_pkg::TEST_OFF;
      end else begin
         rsv_r <= RSSI_QUERY_I && cmd_en; // [R21]
         if (RSSI_QUERY_I && cmd_en) begin
            rsd_r <= RSSI_I;
         end
         nv_r <= tst_cont ? test_r : modem_pkg::TEST_OFF; // [R18]
      end
   end

   assign REG_RDATA_O     = rdata_r;
   assign CTS_O           = cts_r;
   assign SER_OUT_VALID_O = sov_r;
   assign SER_OUT_DATA_O  = sod_r;
   assign TX_ON_O         = ton_r;
   assign TX_SYNC_O       = tsync_r;
   assign TX_VALID_O      = txv_r;
   assign TX_DATA_O       = txd_r;
   assign RSSI_VALID_O    = rsv_r;
   assign RSSI_O          = rsd_r;
   assign NV_TEST_O       = nv_r;
endmodule // modem_datapath

// ### src/modem_pkg.sv
// Shared constants, types and helpers for the modem data path
package modem_pkg;
   // Clock and timing
   localparam int CLK_KHZ      = 25000;
   localparam int SYNC_US      = 1000;
   localparam int SHORT_GAP_MS = 200;
   localparam int LONG_ON_MS   = 40000;
   localparam int LONG_OFF_MS  = 10000;

   // Buffers
   localparam int BUF_DEPTH = 1024;
   localparam int AW        = 10;
   localparam int CW        = 11;
   localparam logic [CW-1:0] CTS_LEVEL = 11'h3c0;

   // Register indexes
   localparam logic [3:0] REG_CFG  = 4'h0;
   localparam logic [3:0] REG_TEST = 4'h1;
   localparam logic [3:0] REG_STAT = 4'h2;
   localparam logic [3:0] REG_LVL  = 4'h3;

   // Config fields
   localparam int CFG_MODE_LSB  = 0;
   localparam int MODE_W        = 3;
   localparam int CFG_CMD_BIT   = 3;
   localparam int CFG_PAUSE_LSB = 8;
   localparam int PAUSE_W       = 8;
   localparam logic [15:0] CFG_RST = 16'h0300;

   // Protocol modes
   localparam logic [2:0] MODE_RX_PRIO = 3'h0;
   localparam logic [2:0] MODE_TX_PRIO = 3'h1;
   localparam logic [2:0] MODE_REPEAT  = 3'h2;
   localparam logic [2:0] MODE_ADV_MST = 3'h3;
   localparam logic [2:0] MODE_ADV_SLV = 3'h4;

   // Test modes
   localparam int TEST_W = 3;
   localparam logic [2:0] TEST_OFF    = 3'h0;
   localparam logic [2:0] TEST_SHORT  = 3'h1;
   localparam logic [2:0] TEST_LONG   = 3'h2;
   localparam logic [2:0] TEST_CSHORT = 3'h3;
   localparam logic [2:0] TEST_CLONG  = 3'h4;
   localparam logic [3:0] TEST_LEN    = 4'ha;

   typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_SYNC, ST_SEND, ST_GAP} state_t;
   typedef enum logic [1:0] {SRC_SER, SRC_FWD, SRC_TEST} src_t;

   function automatic logic [7:0] hex_ascii(input logic [3:0] n);
      return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   // Test line: "$" seq(hex) ",test," LF
   function automatic logic [7:0] test_byte(input logic [3:0] idx, input logic [7:0] seq);
      case (idx)
         4'h0:    return 8'h24;
         4'h1:    return hex_ascii(seq[7:4]);
         4'h2:    return hex_ascii(seq[3:0]);
         4'h3:    return 8'h2c;
         4'h4:    return 8'h74;
         4'h5:    return 8'h65;
         4'h6:    return 8'h73;
         4'h7:    return 8'h74;
         4'h8:    return 8'h2c;
         default: return 8'h0a;
      endcase
   endfunction
endpackage

// ### verif/modem_datapath_bench.sv
// Self-checking bench for the modem data path
`timescale 1ns/1ps
module modem_datapath_bench;
   logic        clk = 0, rst = 1, wr = 0, rd = 0, sv = 0, tick = 0, sync = 0, rv = 0, rend = 0;
   logic        adv = 0, loc = 0, fwd = 0, q = 0, slow = 0, trdy, srdy, cts, sov, ton, tsy, tv, rsv;
   logic [3:0]  ad = 0;
   logic [15:0] wd = 0, rdat;
   logic [7:0]  sd = 0, rb = 0, rs = 0, sod, txd, rso;
   logic [2:0]  nv = 0, nvo;
   logic [7:0]  txq[$];
   int          n_fail = 0, n_compared = 0, cyc = 0, n_so = 0, t0;

   modem_datapath #(.SYNC_CYCLES(4), .SHORT_GAP_CYCLES(50), .LONG_ON_CYCLES(200), .LONG_OFF_CYCLES(50))
   i_modem_datapath (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(ad), .REG_WDATA_I(wd), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_RDATA_O(rdat), .SER_VALID_I(sv), .SER_DATA_I(sd), .CHAR_TICK_I(tick), .CTS_O(cts),
      .SER_OUT_VALID_O(sov), .SER_OUT_DATA_O(sod), .SER_OUT_READY_I(srdy), .RF_SYNC_DET_I(sync),
      .RF_RX_VALID_I(rv), .RF_RX_DATA_I(rb), .RF_RX_END_I(rend), .RF_RX_ADV_I(adv), .RF_RX_LOCAL_I(loc),
      .RF_RX_FWD_I(fwd), .TX_ON_O(ton), .TX_SYNC_O(tsy), .TX_VALID_O(tv), .TX_DATA_O(txd), .TX_READY_I(trdy),
      .RSSI_QUERY_I(q), .RSSI_I(rs), .RSSI_VALID_O(rsv), .RSSI_O(rso), .NV_TEST_I(nv), .NV_TEST_O(nvo));
   modem_far_side i_modem_far_side (.clk_i(clk), .rst_i(rst), .slow_i(slow), .tx_ready_o(trdy),
      .ser_ready_o(srdy));

   always #20 clk = !clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      tick <= (cyc % 8 == 0);
      if (tv === 1'b1 && trdy) txq.push_back(txd);
      if (sov === 1'b1 && srdy) n_so++;
      if (cyc == 9000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rg(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      ad <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 0;
      rd <= 0;
      #1;
   endtask

   task automatic sb(input logic [7:0] b, input logic ign);
      for (int i = 0; i < 3000 && !ign && cts !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      sv <= 1;
      sd <= b;
      @(posedge clk);
      sv <= 0;
   endtask

   task automatic ev(input logic s, input logic e);
      @(posedge clk);
      sync <= s;
      rend <= e;
      @(posedge clk);
      sync <= 0;
      rend <= 0;
   endtask

   task automatic rx(input logic [7:0] b, input logic a, input logic f);
      @(posedge clk);
      rv <= 1;
      rb <= b;
      adv <= a;
      fwd <= f;
      @(posedge clk);
      rv <= 0;
   endtask

   task automatic wt(input logic v, input int n);
      for (int i = 0; i < n && ton !== v; i++) @(posedge clk) #1;
      chk({15'h0, ton}, {15'h0, v});
   endtask

   // Off-air bytes are compared in order against the expected text
   task automatic cq(input string m);
      chk(16'(txq.size()), 16'(m.len()));
      for (int i = 0; i < m.len() && i < txq.size(); i++) chk({8'h0, txq[i]}, {8'h0, m[i]});
      txq.delete();
   endtask

   task automatic wrap_up();
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      rg(0, 4'h0, 0);
      chk(rdat, 16'h0300);
      rg(1, 4'h5, 16'hffff);
      rg(0, 4'h5, 0);
      chk(rdat, 16'h0000);
      sb(8'h31, 0);
      wt(1, 8);
      sb(8'h32, 0);
      sb(8'h33, 0);
      wt(0, 400);
      cq("123");
      // Repeater: serial byte waits behind the forwarded one
      rg(1, 4'h0, 16'h0302);
      slow <= 1;
      ev(1, 0);
      sb(8'h44, 0);
      rx(8'h5a, 0, 1);
      rx(8'ha5, 1, 1);
      repeat (30) @(posedge clk) #1;
      chk({15'h0, ton}, 16'h0000);
      chk(16'(n_so), 16'h0001);
      rg(0, 4'h3, 0);
      chk(rdat, 16'h0001);
      ev(0, 1);
      for (int i = 0; i < 600 && txq.size() < 2; i++) @(posedge clk);
      wt(0, 400);
      cq("ZD");
      // Terminal ignores flow control while held in receive
      slow <= 0;
      rg(1, 4'h0, 16'h0300);
      ev(1, 0);
      for (int i = 0; i < 1024; i++) sb(i[7:0], 1);
      rg(0, 4'h3, 0);
      chk(rdat, 16'h0400);
      chk({15'h0, cts}, 16'h0000);
      chk({15'h0, ton}, 16'h0000);
      sb(8'h00, 1);
      rg(0, 4'h3, 0);
      chk(rdat, 16'h0000);
      ev(0, 1);
      rg(1, 4'h0, 16'h0301);
      ev(1, 0);
      sb(8'h55, 0);
      wt(1, 8);
      wt(0, 400);
      ev(0, 1);
      txq.delete();
      slow <= 1;
      rg(1, 4'h1, 16'h0001);
      wt(1, 10);
      wt(0, 400);
      cq("$00,test,\n");
      repeat (40) @(posedge clk) #1;
      chk({15'h0, ton}, 16'h0000);
      wt(1, 30);
      wt(0, 400);
      cq("$01,test,\n");
      rg(1, 4'h1, 16'h0002);
      wt(1, 60);
      t0 = cyc;
      wt(0, 400);
      chk(16'(cyc - t0 >= 198), 16'h0001);
      repeat (45) @(posedge clk) #1;
      chk({15'h0, ton}, 16'h0000);
      wt(1, 30);
      rg(1, 4'h1, 16'h0000);
      for (int e = 0; e < 2; e++) begin
         rg(1, 4'h0, {12'h030, e[0], 3'h0});
         @(posedge clk);
         q <= 1;
         rs <= 8'h42;
         @(posedge clk);
         q <= 0;
         #1;
         chk({15'h0, rsv}, {15'h0, e[0]});
      end
      chk({8'h0, rso}, 16'h0042);
      @(posedge clk);
      nv <= 3'h3;
      rst <= 1;
      repeat (16) @(posedge clk);
      rst <= 0;
      rg(0, 4'h1, 0);
      chk(rdat, 16'h0003);
      chk({13'h0, nvo}, 16'h0003);
      wrap_up();
   end
endmodule // modem_datapath_bench

// ### verif/modem_datapath_checker.sv
// Port-level assertions for the modem data path
`timescale 1ns/1ps
module modem_datapath_checker #(
   parameter int SYNC_CYCLES = 4
) (
   input wire logic        REF_CLK_I,       // Clock
   input wire logic        SYS_RST_I,       // Reset
   input wire logic        REG_RD_I,        // Read strobe
   input wire logic [15:0] REG_RDATA_O,     // Read data
   input wire logic        TX_ON_O,         // Keyed
   input wire logic        TX_SYNC_O,       // Sync phase
   input wire logic        TX_VALID_O,      // Tx byte valid
   input wire logic [7:0]  TX_DATA_O,       // Tx byte
   input wire logic        TX_READY_I,      // Tx accept
   input wire logic        SER_OUT_VALID_O, // Serial out valid
   input wire logic [7:0]  SER_OUT_DATA_O,  // Serial out byte
   input wire logic        SER_OUT_READY_I, // Serial accept
   input wire logic        RSSI_QUERY_I,    // Query
   input wire logic [7:0]  RSSI_I,          // Strength
   input wire logic        RSSI_VALID_O,    // Answer pulse
   input wire logic [7:0]  RSSI_O,          // Answer
   input wire logic [2:0]  NV_TEST_O        // Stored test mode
);
   int unsigned sync_cnt_r;

   always_ff @(posedge REF_CLK_I) begin
      sync_cnt_r <= (SYS_RST_I || !TX_SYNC_O) ? 0 : sync_cnt_r + 1;
   end

   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   property p_sync_first; $rose(TX_ON_O) |-> TX_SYNC_O; endproperty
   a_sync_first: assert property (p_sync_first) else $error("keyed without sync");
   property p_sync_keyed; TX_SYNC_O |-> TX_ON_O; endproperty
   a_sync_keyed: assert property (p_sync_keyed) else $error("sync while unkeyed");
   property p_sync_len; $fell(TX_SYNC_O) && TX_ON_O |-> sync_cnt_r == SYNC_CYCLES; endproperty
   a_sync_len: assert property (p_sync_len) else $error("sync length wrong");
   property p_tx_hold; TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
   property p_ser_hold; SER_OUT_VALID_O && !SER_OUT_READY_I |=> SER_OUT_VALID_O && $stable(SER_OUT_DATA_O);
   endproperty
   a_ser_hold: assert property (p_ser_hold) else $error("serial byte dropped");
   property p_rssi; RSSI_VALID_O |-> $past(RSSI_QUERY_I) && RSSI_O == $past(RSSI_I); endproperty
   a_rssi: assert property (p_rssi) else $error("unasked or wrong answer");
   property p_nv; NV_TEST_O == 3'h0 || NV_TEST_O == 3'h3 || NV_TEST_O == 3'h4; endproperty
   a_nv: assert property (p_nv) else $error("bad stored test mode");
   property p_rdata; REG_RDATA_O != 16'h0000 |-> $past(REG_RD_I); endproperty
   a_rdata: assert property (p_rdata) else $error("read data unasked");

   c_key: cover property ($rose(TX_ON_O));
   c_stall: cover property (TX_VALID_O && !TX_READY_I);
   c_rssi: cover property (RSSI_VALID_O);
endmodule // modem_datapath_checker

bind modem_datapath modem_datapath_checker #(.SYNC_CYCLES(SYNC_CYCLES)) i_modem_datapath_checker (
   .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
   .TX_ON_O(TX_ON_O), .TX_SYNC_O(TX_SYNC_O), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O),
   .TX_READY_I(TX_READY_I), .SER_OUT_VALID_O(SER_OUT_VALID_O), .SER_OUT_DATA_O(SER_OUT_DATA_O),
   .SER_OUT_READY_I(SER_OUT_READY_I), .RSSI_QUERY_I(RSSI_QUERY_I), .RSSI_I(RSSI_I),
   .RSSI_VALID_O(RSSI_VALID_O), .RSSI_O(RSSI_O), .NV_TEST_O(NV_TEST_O));

// ### verif/modem_far_side.sv
// Far-side model: modulator and terminal serial port acceptance
`timescale 1ns/1ps
module modem_far_side (
   input  wire logic clk_i,       // Clock
   input  wire logic rst_i,       // Reset
   input  wire logic slow_i,      // Stall every other cycle
   output logic      tx_ready_o,  // Modulator accepts
   output logic      ser_ready_o  // Terminal accepts
);
   logic tog_r;

   always_ff @(posedge clk_i) begin
      tog_r <= rst_i ? 1'b0 : !tog_r;
   end

   // Ready ignores valid, so the block must hold its offer
   assign tx_ready_o  = !slow_i || tog_r;
   assign ser_ready_o = !slow_i || !tog_r;
endmodule // modem_far_side
